// ==== logic/scd_cfg.svh ====
// register map, field positions, reset values and timing constants of the sample clock divider
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SCD_ADDR_W          12
`define SCD_ADDR_SYNC_CTRL  12'h100
`define SCD_ADDR_DIV_CTRL   12'h101
`define SCD_ADDR_FIX_CTRL   12'h102
`define SCD_ADDR_STATUS     12'h103

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCD_SYNC_EN_BIT     1
`define SCD_SYNC_ONCE_BIT   2
`define SCD_FIX_EN_BIT      0
`define SCD_ST_ARMED_BIT    0
`define SCD_ST_SEEN_BIT     1
`define SCD_ST_LOCKED_BIT   2
`define SCD_ST_CONV_BIT     3
`define SCD_DIV_W           3
`define SCD_DIV_MIN         3'h1
`define SCD_DIV_MAX         3'h6
`define SCD_DIV_RST         3'h1
`define SCD_FIX_RST         1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define SCD_CLK_MHZ         125
`define SCD_FIX_MIN_MHZ     20
`define SCD_FIX_MAX_PER     (`SCD_CLK_MHZ / `SCD_FIX_MIN_MHZ)
`define SCD_RELOCK_NS       1500
`define SCD_RELOCK_CYC      ((`SCD_RELOCK_NS * `SCD_CLK_MHZ + 999) / 1000)
`define SCD_PER_W           8
`define SCD_PER_MAX         8'hff

`endif

// ==== logic/scd_pkg.sv ====
// state type used by the duty fixer of the sample clock divider
package scd_pkg;

	typedef enum logic [1:0] {
		FX_OFF,
		FX_MEASURE,
		FX_SETTLE,
		FX_LOCK
	} scd_fix_state_t;

endpackage

// ==== logic/scd_fix_if.sv ====
// link between the divider and its duty fixer
interface scd_fix_if;
	logic enable;
	logic in_rise;
	logic out_rise;
	logic fall_now;
	logic locked;

	modport divider (
		output enable,
		output in_rise,
		output out_rise,
		input  fall_now,
		input  locked
	);

	modport fixer (
		input  enable,
		input  in_rise,
		input  out_rise,
		output fall_now,
		output locked
	);
endinterface

// ==== logic/scd_pin_sync.sv ====
// two-stage pin synchroniser with edge pulses
module scd_pin_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin
	input  wire logic pin,
	// synchronised view
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic last_q;
	logic last_d;

	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
		last_d = sync_q;
		rise   = sync_q & ~last_q;
		fall   = ~sync_q & last_q;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end
endmodule

// ==== logic/scd_duty_fixer.sv ====
// duty fixer: measures the output period and places the falling edge at its middle
`include "scd_cfg.svh"

module scd_duty_fixer (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// divider link
	scd_fix_if.fixer  fx
);
	scd_pkg::scd_fix_state_t           state_q;
	scd_pkg::scd_fix_state_t           state_d;
	logic [`SCD_PER_W-1:0]             in_cyc_q;
	logic [`SCD_PER_W-1:0]             in_cyc_d;
	logic [`SCD_PER_W-1:0]             in_per_q;
	logic [`SCD_PER_W-1:0]             in_per_d;
	logic [`SCD_PER_W-1:0]             out_cyc_q;
	logic [`SCD_PER_W-1:0]             out_cyc_d;
	logic [`SCD_PER_W-1:0]             out_per_q;
	logic [`SCD_PER_W-1:0]             out_per_d;
	logic [`SCD_PER_W-1:0]             wait_q;
	logic [`SCD_PER_W-1:0]             wait_d;
	logic [`SCD_PER_W-1:0]             new_per;
	logic                              slow;

	// sampled edges jitter by one cycle, so only a larger step counts as a change
	function automatic logic moved(input logic [`SCD_PER_W-1:0] a, input logic [`SCD_PER_W-1:0] b);
		moved = (a > b) ? ((a - b) > 8'h01) : ((b - a) > 8'h01);
	endfunction

	function automatic logic [`SCD_PER_W-1:0] bump(input logic [`SCD_PER_W-1:0] v);
		bump = (v == `SCD_PER_MAX) ? v : v + 8'h01;
	endfunction

	always_comb begin
		in_cyc_d  = fx.in_rise ? 8'h00 : bump(in_cyc_q);
		in_per_d  = fx.in_rise ? bump(in_cyc_q) : in_per_q;
		new_per   = bump(out_cyc_q);
		out_cyc_d = fx.out_rise ? 8'h00 : new_per;
		out_per_d = fx.out_rise ? new_per : out_per_q;
		// loop not guaranteed below the minimum input rate
		slow      = (in_per_q == 8'h00) || (in_per_q > 8'(`SCD_FIX_MAX_PER));
		state_d   = state_q;
		wait_d    = wait_q;
		case (state_q)
			scd_pkg::FX_OFF: begin
				if (fx.enable) begin
					state_d = scd_pkg::FX_MEASURE;
				end
			end
			scd_pkg::FX_MEASURE: begin
				if (fx.out_rise && (out_per_q != 8'h00) && !slow) begin
					state_d = scd_pkg::FX_SETTLE;
					wait_d  = 8'h00;
				end
			end
			scd_pkg::FX_SETTLE: begin
				wait_d = bump(wait_q);
				if (slow) begin
					state_d = scd_pkg::FX_MEASURE;
				end else if (fx.out_rise && moved(new_per, out_per_q)) begin
					wait_d = 8'h00;
				end else if (wait_q == 8'(`SCD_RELOCK_CYC)) begin
					state_d = scd_pkg::FX_LOCK;
				end
			end
			default: begin
				if (slow) begin
					state_d = scd_pkg::FX_MEASURE;
				end else if (fx.out_rise && moved(new_per, out_per_q)) begin
					state_d = scd_pkg::FX_SETTLE;
					wait_d  = 8'h00;
				end
			end
		endcase
		if (!fx.enable) begin
			state_d = scd_pkg::FX_OFF;
		end
		fx.locked   = (state_q == scd_pkg::FX_LOCK);
		// new_per counts this cycle too, so the high phase is half the period, rounded down
		fx.fall_now = fx.locked && !fx.out_rise && (new_per == (out_per_q >> 1));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= scd_pkg::FX_OFF;
			in_cyc_q  <= 8'h00;
			in_per_q  <= 8'h00;
			out_cyc_q <= 8'h00;
			out_per_q <= 8'h00;
			wait_q    <= 8'h00;
		end else begin
			state_q   <= state_d;
			in_cyc_q  <= in_cyc_d;
			in_per_q  <= in_per_d;
			out_cyc_q <= out_cyc_d;
			out_per_q <= out_per_d;
			wait_q    <= wait_d;
		end
	end
endmodule

// ==== logic/scd_top.sv ====
// sample clock divider with sync reset, duty fixer and register port
//
// The address-and-strobe port was chosen for this implementation.
`include "scd_cfg.svh"

module scd_top (
	// clock and reset
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	// register port
	input  wire logic [`SCD_ADDR_W-1:0] REG_ADDR,
	input  wire logic [7:0]             REG_WDATA,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	output logic      [7:0]             REG_RDATA,
	// pins
	input  wire logic                   SAMPLE_CLK_IN,
	input  wire logic                   SYNC_IN,
	// conversion clock
	output logic                        CONV_CLK,
	output logic                        SAMPLE_STROBE,
	output logic                        SYNC_APPLIED
);
	scd_fix_if fx ();

	logic                  in_rise;
	logic                  in_fall;
	logic                  sync_rise;

	logic                  sync_en_q;
	logic                  sync_en_d;
	logic                  sync_once_q;
	logic                  sync_once_d;
	logic                  armed_q;
	logic                  armed_d;
	logic                  seen_q;
	logic                  seen_d;
	logic [`SCD_DIV_W-1:0] div_q;
	logic [`SCD_DIV_W-1:0] div_d;
	logic                  fix_en_q;
	logic                  fix_en_d;
	logic [`SCD_DIV_W-1:0] cnt_q;
	logic [`SCD_DIV_W-1:0] cnt_d;
	logic [`SCD_DIV_W-1:0] cnt_nxt;
	logic                  conv_q;
	logic                  conv_d;
	logic                  strobe_q;
	logic                  strobe_d;
	logic                  applied_q;
	logic                  applied_d;
	logic [7:0]            rdata_q;
	logic [7:0]            rdata_d;
	logic                  sync_ok;
	logic                  rise_now;
	logic                  wr_sync;

	function automatic logic is_addr(input logic [`SCD_ADDR_W-1:0] a,
			input logic [`SCD_ADDR_W-1:0] b);
		is_addr = (a == b);
	endfunction

	// ----------------------------------------
	// pin synchronisers and duty fixer
	// ----------------------------------------
	scd_pin_sync u_clk_pin (
		.clk  (CLK),
		.rst  (RESET),
		.pin  (SAMPLE_CLK_IN),
		.rise (in_rise),
		.fall (in_fall)
	);

	scd_pin_sync u_sync_pin (
		.clk  (CLK),
		.rst  (RESET),
		.pin  (SYNC_IN),
		.rise (sync_rise),
		.fall ()
	);

	scd_duty_fixer u_fixer (
		.clk (CLK),
		.rst (RESET),
		.fx  (fx)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_comb begin
		wr_sync     = REG_WR && is_addr(REG_ADDR, `SCD_ADDR_SYNC_CTRL);
		// every-pulse mode, or first pulse after a write while still armed
		sync_ok     = sync_rise && sync_en_q && (!sync_once_q || armed_q);
		sync_en_d   = sync_en_q;
		sync_once_d = sync_once_q;
		armed_d     = armed_q;
		div_d       = div_q;
		fix_en_d    = fix_en_q;
		seen_d      = seen_q;
		if (sync_ok && sync_once_q) begin
			armed_d = 1'b0;
		end
		if (wr_sync) begin
			sync_en_d   = REG_WDATA[`SCD_SYNC_EN_BIT];
			sync_once_d = REG_WDATA[`SCD_SYNC_ONCE_BIT];
			armed_d     = 1'b1;
		end
		if (REG_WR && is_addr(REG_ADDR, `SCD_ADDR_DIV_CTRL)) begin
			// out-of-range ratios are dropped, the old ratio stays
			if ((REG_WDATA[`SCD_DIV_W-1:0] >= `SCD_DIV_MIN) &&
					(REG_WDATA[`SCD_DIV_W-1:0] <= `SCD_DIV_MAX) &&
					(REG_WDATA[7:`SCD_DIV_W] == 5'h00)) begin
				div_d = REG_WDATA[`SCD_DIV_W-1:0];
			end
		end
		if (REG_WR && is_addr(REG_ADDR, `SCD_ADDR_FIX_CTRL)) begin
			fix_en_d = REG_WDATA[`SCD_FIX_EN_BIT];
		end
		if (REG_WR && is_addr(REG_ADDR, `SCD_ADDR_STATUS) && REG_WDATA[`SCD_ST_SEEN_BIT]) begin
			seen_d = 1'b0;
		end
		// a sync that lands on the clearing write is still recorded
		if (sync_ok) begin
			seen_d = 1'b1;
		end
		rdata_d = 8'h00;
		if (REG_RD) begin
			if (is_addr(REG_ADDR, `SCD_ADDR_SYNC_CTRL)) begin
				rdata_d[`SCD_SYNC_EN_BIT]   = sync_en_q;
				rdata_d[`SCD_SYNC_ONCE_BIT] = sync_once_q;
			end else if (is_addr(REG_ADDR, `SCD_ADDR_DIV_CTRL)) begin
				rdata_d[`SCD_DIV_W-1:0] = div_q;
			end else if (is_addr(REG_ADDR, `SCD_ADDR_FIX_CTRL)) begin
				rdata_d[`SCD_FIX_EN_BIT] = fix_en_q;
			end else if (is_addr(REG_ADDR, `SCD_ADDR_STATUS)) begin
				rdata_d[`SCD_ST_ARMED_BIT]  = armed_q;
				rdata_d[`SCD_ST_SEEN_BIT]   = seen_q;
				rdata_d[`SCD_ST_LOCKED_BIT] = fx.locked;
				rdata_d[`SCD_ST_CONV_BIT]   = conv_q;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			sync_en_q   <= 1'b0;
			sync_once_q <= 1'b0;
			armed_q     <= 1'b0;
			seen_q      <= 1'b0;
			div_q       <= `SCD_DIV_RST;
			fix_en_q    <= `SCD_FIX_RST;
			rdata_q     <= 8'h00;
		end else begin
			sync_en_q   <= sync_en_d;
			sync_once_q <= sync_once_d;
			armed_q     <= armed_d;
			seen_q      <= seen_d;
			div_q       <= div_d;
			fix_en_q    <= fix_en_d;
			rdata_q     <= rdata_d;
		end
	end

	// ----------------------------------------
	// divider
	// ----------------------------------------
	always_comb begin
		fx.enable  = fix_en_q;
		fx.in_rise = in_rise;
		cnt_nxt    = cnt_q + 3'h1;
		cnt_d      = cnt_q;
		conv_d     = conv_q;
		rise_now   = 1'b0;
		applied_d  = 1'b0;
		if (sync_ok) begin
			// back to the initial phase, counting restarts at zero
			cnt_d     = 3'h0;
			conv_d    = 1'b0;
			applied_d = 1'b1;
		end else begin
			if (in_rise) begin
				// >= so a ratio lowered mid-count still wraps at once
				if (cnt_nxt >= div_q) begin
					cnt_d    = 3'h0;
					conv_d   = 1'b1;
					rise_now = 1'b1;
				end else begin
					cnt_d = cnt_nxt;
				end
			end
			// checked apart from the input rise, else a fall due in that cycle is lost
			if (conv_q && !rise_now && (fx.locked ? fx.fall_now : in_fall)) begin
				conv_d = 1'b0;
			end
		end
		fx.out_rise = rise_now;
		strobe_d    = rise_now;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cnt_q     <= 3'h0;
			conv_q    <= 1'b0;
			strobe_q  <= 1'b0;
			applied_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			conv_q    <= conv_d;
			strobe_q  <= strobe_d;
			applied_q <= applied_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		REG_RDATA     = rdata_q;
		CONV_CLK      = conv_q;
		SAMPLE_STROBE = strobe_q;
		SYNC_APPLIED  = applied_q;
	end
endmodule

// ==== test/scd_top_assertions.sv ====
// port checker for the sample clock divider, bound to scd_top
`include "scd_cfg.svh"

module scd_top_assertions (
	// clock and reset
	input wire logic                   CLK,
	input wire logic                   RESET,
	// register port
	input wire logic [`SCD_ADDR_W-1:0] REG_ADDR,
	input wire logic [7:0]             REG_WDATA,
	input wire logic                   REG_WR,
	input wire logic                   REG_RD,
	input wire logic [7:0]             REG_RDATA,
	// pins and outputs
	input wire logic                   SAMPLE_CLK_IN,
	input wire logic                   SYNC_IN,
	input wire logic                   CONV_CLK,
	input wire logic                   SAMPLE_STROBE,
	input wire logic                   SYNC_APPLIED
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_strobe_rise;
		SAMPLE_STROBE |-> CONV_CLK && !$past(CONV_CLK);
	endproperty
	a_strobe_rise: assert property (p_strobe_rise) else $error("strobe without rise");

	property p_rise_strobe;
		$rose(CONV_CLK) |-> SAMPLE_STROBE;
	endproperty
	a_rise_strobe: assert property (p_rise_strobe) else $error("rise without strobe");

	property p_strobe_pulse;
		SAMPLE_STROBE |=> !SAMPLE_STROBE;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

	property p_sync_low;
		SYNC_APPLIED |-> !CONV_CLK;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("clock high at sync");

	property p_sync_restart;
		SYNC_APPLIED |=> !SAMPLE_STROBE && !SYNC_APPLIED;
	endproperty
	a_sync_restart: assert property (p_sync_restart) else $error("early strobe");

	property p_rd_idle;
		!$past(REG_RD) |-> REG_RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

	property p_rd_unmapped;
		$past(REG_RD) && ($past(REG_ADDR) < `SCD_ADDR_SYNC_CTRL ||
			$past(REG_ADDR) > `SCD_ADDR_STATUS) |-> REG_RDATA == 8'h00;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");

	property p_ratio_rd;
		$past(REG_RD) && $past(REG_ADDR) == `SCD_ADDR_DIV_CTRL |->
			REG_RDATA inside {[8'h01:8'h06]};
	endproperty
	a_ratio_rd: assert property (p_ratio_rd) else $error("ratio out of range");

	c_sync: cover property (SYNC_APPLIED);
	c_strobe: cover property (SAMPLE_STROBE);
	c_unmapped: cover property ($past(REG_RD) && $past(REG_ADDR) > `SCD_ADDR_STATUS);
endmodule

bind scd_top scd_top_assertions i_chk (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.SAMPLE_CLK_IN(SAMPLE_CLK_IN), .SYNC_IN(SYNC_IN), .CONV_CLK(CONV_CLK),
	.SAMPLE_STROBE(SAMPLE_STROBE), .SYNC_APPLIED(SYNC_APPLIED));

// ==== test/scd_src_model.sv ====
// sample clock source and sync driver facing the divider
module scd_src_model #(
	parameter int HALF = 3
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic sync_go,
	output logic      clk_out,
	output logic      sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int ph;
	int sl;
	// clock stands low while stopped; pulse held 4 cycles so both edges get sampled
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			ph <= 0;
			clk_out <= 1'b0;
		end else if (ph == HALF - 1) begin
			ph <= 0;
			clk_out <= !clk_out;
		end else
			ph <= ph + 1;
		if (rst)
			sl <= 0;
		else if (sync_go)
			sl <= 4;
		else if (sl != 0)
			sl <= sl - 1;
	end
	assign sync_out = (sl != 0);
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the sample clock divider
`include "scd_cfg.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 6;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, go = 1'b0;
	logic [11:0] addr = '0;
	logic [7:0] wdata = '0, rv, rdata;
	logic smp, sync_pin, conv, strobe, applied;
	int n_mismatch = 0, check_count = 0, cyc = 0, n_app = 0, g, v;
	logic [7:0] modes [5] = '{8'h02, 8'h06, 8'h06, 8'h00, 8'h04};
	int exp_n [5] = '{2, 1, 1, 0, 0};
	int exp_arm [5] = '{1, 0, 0, 1, 1};

	always #4 clk = ~clk;

	scd_top i_scd_top (.CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SAMPLE_CLK_IN(smp),
		.SYNC_IN(sync_pin), .CONV_CLK(conv), .SAMPLE_STROBE(strobe), .SYNC_APPLIED(applied));
	scd_src_model #(.HALF(P / 2)) i_scd_src_model (.clk(clk), .rst(rst), .run(run),
		.sync_go(go), .clk_out(smp), .sync_out(sync_pin));

	always @(negedge clk) if (applied === 1'b1) n_app++;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end

	function automatic int exp_high(input bit fix, input int n);
		return fix ? n * P / 2 : P / 2;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// count cycles at falling edges until the condition or the bound
	task automatic wait_strobe();
		int k;
		k = 0;
		@(negedge clk);
		while (strobe !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
	endtask
	task automatic strobe_gap(output int n);
		wait_strobe();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (strobe !== 1'b1 && n < 500);
	endtask
	task automatic high_len(output int n);
		wait_strobe();
		n = 0;
		while (conv === 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic pulse();
		repeat ($urandom_range(0, 5)) @(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		v = $urandom(32'h0dab39fd);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_reg(`SCD_ADDR_SYNC_CTRL, rv); check(rv, 8'h00);
		rd_reg(`SCD_ADDR_DIV_CTRL, rv); check(rv, 8'h01);
		rd_reg(`SCD_ADDR_FIX_CTRL, rv); check(rv, 8'h01);
		rd_reg(12'h104, rv); check(rv, 8'h00);
		rd_reg(12'h0ff, rv); check(rv, 8'h00);
		run <= 1'b1;
		wr_reg(`SCD_ADDR_FIX_CTRL, 8'h00);
		for (int n = 1; n <= 6; n++) begin
			wr_reg(`SCD_ADDR_DIV_CTRL, n[7:0]);
			rd_reg(`SCD_ADDR_DIV_CTRL, rv); check(rv, n);
			strobe_gap(g);
			strobe_gap(g); check(g, n * P);
			high_len(g); check(g, exp_high(0, n));
		end
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 0 : $urandom_range(7, 255);
			wr_reg(`SCD_ADDR_DIV_CTRL, v[7:0]);
			rd_reg(`SCD_ADDR_DIV_CTRL, rv); check(rv, 8'h06);
		end
		wr_reg(`SCD_ADDR_FIX_CTRL, 8'h01);
		for (int n = 3; n <= 5; n += 2) begin
			wr_reg(`SCD_ADDR_DIV_CTRL, n[7:0]);
			repeat (400) @(posedge clk);
			high_len(g); check(g, exp_high(1, n));
			rd_reg(`SCD_ADDR_STATUS, rv); check(rv & 8'h04, 8'h04);
		end
		// a long stop looks like a very slow input, so the fixer must drop lock
		run <= 1'b0;
		repeat (300) @(posedge clk);
		run <= 1'b1;
		repeat (30) @(posedge clk);
		rd_reg(`SCD_ADDR_STATUS, rv); check(rv & 8'h04, 8'h00);
		wr_reg(`SCD_ADDR_DIV_CTRL, 8'h04);
		for (int m = 0; m < 5; m++) begin
			wr_reg(`SCD_ADDR_SYNC_CTRL, modes[m]);
			n_app = 0;
			repeat (2) begin
				pulse();
				repeat (30) @(posedge clk);
			end
			check(n_app, exp_n[m]);
			rd_reg(`SCD_ADDR_STATUS, rv); check(rv & 8'h01, exp_arm[m]);
		end
		wr_reg(`SCD_ADDR_SYNC_CTRL, 8'h02);
		for (int i = 0; i < 4; i++) begin
			pulse();
			g = 0;
			while (applied !== 1'b1 && g < 50) begin
				@(negedge clk);
				g++;
			end
			check(g < 50, 1);
			g = 0;
			do begin
				@(negedge clk);
				g++;
			end while (strobe !== 1'b1 && g < 500);
			check(g > 3 * P && g <= 4 * P, 1);
		end
		rd_reg(`SCD_ADDR_STATUS, rv); check(rv & 8'h02, 8'h02);
		wr_reg(`SCD_ADDR_STATUS, 8'h02);
		rd_reg(`SCD_ADDR_STATUS, rv); check(rv & 8'h02, 8'h00);
		finish_test();
	end
endmodule
